// ---- battery_power_ctrl.sv ----
// Purpose: operating state, power gating, scan sequencing, balancing and fault flags
// Assumes: en_pin_in and comm_act_in are asynchronous pins, all else on core_clk_in
// Notes:   results and settings survive shutdown; only rst_b_in clears them
// Behaviour
// - twelve cells, fourteen-bit results kept in registers
// - chain position one to fourteen only
// - two scan modes plus direct single measurement
// - scan steps through cells back to back
// - results stored raw, no averaging
// - fault inputs filtered before flagging
// - manual, timed and automatic balancing
// - detect voltage, regulator, oscillator, wire, link faults
// - fault state readable by host
// - link faults by reply or unsolicited message
// - normal, sleep and shutdown power modes
// - sleep on command or watchdog timeout
// - sleep keeps link input, slow oscillator, registers
// - sleep runs timed scan, balance; wakes on activity
// - enable low forces shutdown
// - shutdown keeps core, sleep regulators, input buffers
// - leaving shutdown skips configuration reload
// - normal mode is standby or active
// - standby fully powered, waits for command
// - active during operation, then back to standby
`timescale 1ns/1ps
`include "pwr_mode_defs.svh"

module battery_power_ctrl
	import pwr_mode_pkg::*;
(
	input  wire logic                   core_clk_in,
	input  wire logic                   rst_b_in,
	input  wire logic                   en_pin_in,
	input  wire logic                   comm_act_in,
	input  wire logic                   supply_ok_in,
	input  wire logic                   sleep_cmd_in,
	input  wire logic                   wdog_to_in,
	input  wire logic                   cmd_rx_in,
	input  wire logic                   op_req_in,
	input  wire op_t                    op_sel_in,
	input  wire logic [3:0]             op_chan_in,
	input  wire logic                   adc_done_in,
	input  wire logic [`ADC_W-1:0]      adc_data_in,
	input  wire logic                   scan_tick_in,
	input  wire logic                   bal_tick_in,
	input  wire bal_mode_t              bal_mode_in,
	input  wire logic [`NUM_CELLS-1:0]  bal_mask_in,
	input  wire logic [`BAL_TIME_W-1:0] bal_time_in,
	input  wire logic                   bal_go_in,
	input  wire logic [`ADC_W-1:0]      ov_lim_in,
	input  wire logic [`ADC_W-1:0]      uv_lim_in,
	input  wire logic                   reg_bad_in,
	input  wire logic                   osc_bad_in,
	input  wire logic                   comm_err_in,
	input  wire logic [3:0]             chain_pos_in,
	input  wire logic [3:0]             rd_addr_in,
	output mode_t                       mode_out,
	output pwr_t                        pwr_out,
	output logic                        adc_start_out,
	output logic [3:0]                  adc_chan_out,
	output logic                        ow_src_out,
	output logic                        busy_out,
	output logic [`ADC_W-1:0]           rd_data_out,
	output fault_t                      fault_out,
	output logic [`NUM_CELLS-1:0]       bal_out,
	output logic                        cmd_pend_out,
	output logic                        comm_reply_err_out,
	output logic                        unsol_msg_out,
	output logic                        nvm_load_out,
	output logic                        chain_err_out
);

	localparam int SETTLE_LAST = `SETTLE_CYC - 1;

	mode_t                  st_r, st_nxt;
	pwr_t                   pwr_r;
	logic [1:0]             en_sync_r, act_sync_r;
	logic                   act_last_r;
	logic                   en_s, act_rise;
	logic [`SETTLE_W-1:0]   settle_cnt_r;
	logic                   first_boot_r;
	logic                   cmd_pend_r;
	logic                   seq_busy_r, seq_done;
	op_t                    seq_op_r;
	logic [3:0]             chan_r, last_r;
	logic                   seq_start;
	logic [`ADC_W-1:0]      res_r [`NUM_CHAN];
	logic                   ow_hit_r;
	logic [`NUM_FAULTS-1:0] raw_flt, flt_r;
	logic                   ov_raw, uv_raw;
	logic [`ADC_W-1:0]      cell_min;
	logic [`BAL_TIME_W-1:0] bal_timer_r;
	logic [`NUM_CELLS-1:0]  bal_r, bal_nxt, auto_sel;

	// two-flop synchronisers for the pins; only the second flop is read
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
		begin
			en_sync_r  <= 2'h0;
			act_sync_r <= 2'h0;
			act_last_r <= 1'b0;
		end
		else
		begin
			en_sync_r  <= {en_sync_r[0], en_pin_in};
			act_sync_r <= {act_sync_r[0], comm_act_in};
			act_last_r <= act_sync_r[1];
		end
	end

	assign en_s     = en_sync_r[1];
	assign act_rise = act_sync_r[1] && !act_last_r;
	assign seq_done = seq_busy_r && adc_done_in && (chan_r == last_r);

	// next operating state; enable low beats every other cause
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			ST_SHUT:       if (en_s) st_nxt = ST_PWRUP;
			ST_PWRUP:      if (supply_ok_in && settle_cnt_r >= SETTLE_LAST[`SETTLE_W-1:0])
				st_nxt = ST_STBY;
			ST_STBY:
			begin
				if (sleep_cmd_in || wdog_to_in)
					st_nxt = ST_SLEEP;
				else if (op_req_in)
					st_nxt = ST_ACT;
			end
			ST_ACT:        if (seq_done) st_nxt = ST_STBY;
			ST_SLEEP:
			begin
				if (act_rise)
					st_nxt = ST_STBY;
				else if (scan_tick_in)
					st_nxt = ST_SLEEP_SCAN;
			end
			ST_SLEEP_SCAN: if (seq_done) st_nxt = cmd_pend_r ? ST_STBY : ST_SLEEP;
			default:       st_nxt = ST_SHUT;
		endcase
		if (!en_s)
			st_nxt = ST_SHUT;
	end

	// state register and the power enables that follow it
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
		begin
			st_r  <= ST_SHUT;
			pwr_r <= '{default: 1'b0, core: 1'b1, sleep_reg: 1'b1, in_buf: 1'b1};
		end
		else
		begin
			st_r <= st_nxt;
			unique case (st_nxt)
				ST_SHUT:  pwr_r <= '{default: 1'b0, core: 1'b1, sleep_reg: 1'b1,
					in_buf: 1'b1};
				ST_SLEEP, ST_SLEEP_SCAN:
					pwr_r <= '{default: 1'b0, comm_in: 1'b1, lp_osc: 1'b1, regs: 1'b1,
					core: 1'b1, sleep_reg: 1'b1, in_buf: 1'b1};
				default:  pwr_r <= '{default: 1'b1};
			endcase
		end
	end

	// settle wait after enable rises; counts only while powering up
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in || st_r != ST_PWRUP)
			settle_cnt_r <= '0;
		else if (settle_cnt_r != '1)
			settle_cnt_r <= settle_cnt_r + `SETTLE_W'(1);
	end

	// configuration loads once after reset, never on a shutdown exit
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
			first_boot_r <= 1'b1;
		else if (st_r == ST_PWRUP && st_nxt == ST_STBY)
			first_boot_r <= 1'b0;
	end

	assign nvm_load_out = (st_r == ST_PWRUP) && first_boot_r;

	// a wake by link activity leaves a command pending; the shutdown clear wins over the wake
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in || st_nxt == ST_SHUT)
			cmd_pend_r <= 1'b0;
		else if (act_rise && (st_r == ST_SLEEP || st_r == ST_SLEEP_SCAN))
			cmd_pend_r <= 1'b1;
		else if (cmd_rx_in && st_r == ST_STBY)
			cmd_pend_r <= 1'b0;
	end

	assign seq_start = (st_r == ST_STBY && st_nxt == ST_ACT) ||
		(st_r == ST_SLEEP && st_nxt == ST_SLEEP_SCAN);

	// measurement sequencer: one conversion per channel, next one straight after
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in || st_nxt == ST_SHUT)
		begin
			seq_busy_r    <= 1'b0;
			seq_op_r      <= OP_SCAN_VOLT;
			chan_r        <= 4'h0;
			last_r        <= 4'h0;
			adc_start_out <= 1'b0;
		end
		else
		begin
			adc_start_out <= 1'b0;
			if (seq_start)
			begin
				// timed scans in sleep are always cell scans
				seq_op_r      <= (st_r == ST_SLEEP) ? OP_SCAN_VOLT : op_sel_in;
				seq_busy_r    <= 1'b1;
				adc_start_out <= 1'b1;
				unique case ((st_r == ST_SLEEP) ? OP_SCAN_VOLT : op_sel_in)
					OP_DIRECT:   begin chan_r <= op_chan_in; last_r <= op_chan_in; end
					OP_SCAN_ALL: begin chan_r <= 4'h0; last_r <= `LAST_CHAN; end
					default:     begin chan_r <= 4'h0; last_r <= `LAST_CELL; end
				endcase
			end
			else if (seq_busy_r && adc_done_in)
			begin
				if (chan_r == last_r)
					seq_busy_r <= 1'b0;
				else
				begin
					chan_r        <= chan_r + 4'h1;
					adc_start_out <= 1'b1;
				end
			end
		end
	end

	assign adc_chan_out = chan_r;
	assign ow_src_out   = seq_busy_r && (seq_op_r == OP_OPEN_WIRE);
	assign busy_out     = seq_busy_r;

	// result store; raw codes only, so sample time stays exact
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
			res_r <= '{default: '0};
		else if (seq_busy_r && adc_done_in && seq_op_r != OP_OPEN_WIRE)
			res_r[chan_r] <= adc_data_in;
	end

	// host read port for results
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
			rd_data_out <= '0;
		else
			rd_data_out <= res_r[rd_addr_in];
	end

	// open-wire verdict from the last wire test
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in || (seq_start && op_sel_in == OP_OPEN_WIRE && st_r == ST_STBY))
			ow_hit_r <= 1'b0;
		else if (ow_src_out && adc_done_in && adc_data_in < `OW_LIMIT)
			ow_hit_r <= 1'b1;
	end

	// cell limit checks and lowest cell for automatic balancing
	always_comb
	begin
		ov_raw   = 1'b0;
		uv_raw   = 1'b0;
		cell_min = res_r[0];
		for (int i = 0; i < `NUM_CELLS; i++)
		begin
			ov_raw = ov_raw || (res_r[i] > ov_lim_in);
			uv_raw = uv_raw || (res_r[i] < uv_lim_in);
			if (res_r[i] < cell_min)
				cell_min = res_r[i];
		end
	end

	assign raw_flt = {comm_err_in, ow_hit_r, osc_bad_in, reg_bad_in, uv_raw, ov_raw};

	// each fault must hold for several samples; glitches never reach the flags
	for (genvar f = 0; f < `NUM_FAULTS; f++)
	begin : g_filt
		logic [2:0] cnt_r;
		always_ff @(posedge core_clk_in)
		begin
			if (!rst_b_in || !raw_flt[f])
			begin
				cnt_r    <= 3'h0;
				flt_r[f] <= 1'b0;
			end
			else if (cnt_r != `FILT_CNT)
			begin
				cnt_r    <= cnt_r + 3'h1;
				flt_r[f] <= (cnt_r == `FILT_CNT - 3'h1);
			end
		end
	end

	assign fault_out = fault_t'(flt_r);

	// link faults: error reply to a command, otherwise an unsolicited message
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
		begin
			comm_reply_err_out <= 1'b0;
			unsol_msg_out      <= 1'b0;
		end
		else
		begin
			comm_reply_err_out <= cmd_rx_in && flt_r[5];
			unsol_msg_out      <= !cmd_rx_in && raw_flt[5] && !flt_r[5] &&
				(g_filt[5].cnt_r == `FILT_CNT - 3'h1);
		end
	end

	// position outside one to fourteen breaks the chain limit
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
			chain_err_out <= 1'b0;
		else
			chain_err_out <= (chain_pos_in == 4'h0) || (chain_pos_in > `MAX_CHAIN);
	end

	// balance timer ticks on its slow enable
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
			bal_timer_r <= '0;
		else if (bal_go_in)
			bal_timer_r <= bal_time_in;
		else if (bal_tick_in && bal_timer_r != '0)
			bal_timer_r <= bal_timer_r - `BAL_TIME_W'(1);
	end

	// automatic mode picks enabled cells well above the lowest one
	always_comb
	begin
		for (int i = 0; i < `NUM_CELLS; i++)
			auto_sel[i] = (res_r[i] > cell_min + `AUTO_DELTA);
	end

	// balance drive; sleep keeps only the timed mode, shutdown none at all
	always_comb
	begin
		bal_nxt = '0;
		unique case (bal_mode_in)
			BAL_MANUAL: bal_nxt = bal_mask_in;
			BAL_TIMED:  bal_nxt = (bal_timer_r != '0) ? bal_mask_in : '0;
			BAL_AUTO:   bal_nxt = bal_mask_in & auto_sel;
			BAL_OFF:    bal_nxt = '0;
		endcase
		if (st_r == ST_SHUT || st_r == ST_PWRUP)
			bal_nxt = '0;
		else if ((st_r == ST_SLEEP || st_r == ST_SLEEP_SCAN) && bal_mode_in != BAL_TIMED)
			bal_nxt = '0;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
			bal_r <= '0;
		else
			bal_r <= bal_nxt;
	end

	assign bal_out      = bal_r;
	assign mode_out     = st_r;
	assign pwr_out      = pwr_r;
	assign cmd_pend_out = cmd_pend_r;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	a_shutdown_entry: assert property (!en_s |=> st_r == ST_SHUT)
		else $error("enable low did not force shutdown");
	a_shut_power: assert property (st_r == ST_SHUT |-> pwr_r.core && pwr_r.in_buf &&
		pwr_r.sleep_reg && !pwr_r.bias && !pwr_r.analog)
		else $error("shutdown power set wrong");
	a_sleep_power: assert property (st_r == ST_SLEEP |-> pwr_r.comm_in && pwr_r.lp_osc &&
		pwr_r.regs && !pwr_r.main_osc && !pwr_r.bias)
		else $error("sleep power set wrong");
	a_sleep_entry: assert property (st_r == ST_STBY && en_s && (sleep_cmd_in || wdog_to_in)
		|=> st_r == ST_SLEEP)
		else $error("sleep request ignored");
	a_wake_standby: assert property (st_r == ST_SLEEP && en_s && act_rise
		|=> st_r == ST_STBY && cmd_pend_r)
		else $error("wake did not reach standby with command pending");
	a_no_reload: assert property (!first_boot_r |=> !first_boot_r && !nvm_load_out)
		else $error("configuration reloaded after shutdown");
	a_settle_wait: assert property (st_r == ST_PWRUP && st_nxt == ST_STBY
		|-> settle_cnt_r >= SETTLE_LAST && supply_ok_in)
		else $error("standby reached before supplies settled");
	a_active_return: assert property (st_r == ST_ACT && seq_done && en_s
		|=> st_r == ST_STBY && !seq_busy_r)
		else $error("active state did not return to standby");
	a_scan_step: assert property (seq_busy_r && adc_done_in && chan_r != last_r && en_s
		|=> chan_r == $past(chan_r) + 4'h1 && adc_start_out)
		else $error("scan did not step to next channel");
	a_raw_store: assert property (seq_busy_r && adc_done_in && seq_op_r != OP_OPEN_WIRE
		|=> res_r[$past(chan_r)] == $past(adc_data_in))
		else $error("stored result differs from raw code");
	a_fault_filter: assert property ($rose(flt_r[2]) |-> $past(raw_flt[2]) &&
		$past(raw_flt[2], 2) && $past(raw_flt[2], 3) && $past(raw_flt[2], 4))
		else $error("fault flagged without filter delay");
	a_sleep_balance: assert property (st_r == ST_SLEEP && bal_mode_in != BAL_TIMED
		|=> bal_out == '0)
		else $error("non-timed balancing left on in sleep");

endmodule : battery_power_ctrl

// ---- pwr_mode_defs.svh ----
// Purpose: numeric constants for the battery monitor power mode controller
// Assumes: core clock of 50 MHz
// Notes:   times are kept in their own unit, cycle counts are derived
`ifndef PWR_MODE_DEFS_SVH
`define PWR_MODE_DEFS_SVH

`define CLK_PERIOD_NS   20
`define SETTLE_NS       1000
// least time, so rounded up to whole cycles
`define SETTLE_CYC      ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_W        6
`define NUM_CELLS       12
`define NUM_CHAN        16
`define LAST_CELL       4'hb
`define LAST_CHAN       4'hf
`define MAX_CHAIN       4'he
`define ADC_W           14
`define OW_LIMIT        14'h0100
`define AUTO_DELTA      14'h0040
`define FILT_CNT        3'h4
`define NUM_FAULTS      6
`define BAL_TIME_W      8

`endif

// ---- pwr_mode_pkg.sv ----
// Purpose: types shared by the power mode controller
// Assumes: pwr_mode_defs.svh holds the numbers
// Notes:   state codes are written out so that traces stay readable
package pwr_mode_pkg;

	typedef enum logic [2:0] {
		ST_SHUT       = 3'b000,
		ST_PWRUP      = 3'b001,
		ST_STBY       = 3'b010,
		ST_ACT        = 3'b011,
		ST_SLEEP      = 3'b100,
		ST_SLEEP_SCAN = 3'b101
	} mode_t;

	typedef enum logic [1:0] {
		OP_SCAN_VOLT = 2'b00,
		OP_SCAN_ALL  = 2'b01,
		OP_DIRECT    = 2'b10,
		OP_OPEN_WIRE = 2'b11
	} op_t;

	typedef enum logic [1:0] {
		BAL_OFF    = 2'b00,
		BAL_MANUAL = 2'b01,
		BAL_TIMED  = 2'b10,
		BAL_AUTO   = 2'b11
	} bal_mode_t;

	typedef struct packed {
		logic bias;
		logic main_osc;
		logic analog;
		logic comm_in;
		logic lp_osc;
		logic regs;
		logic core;
		logic sleep_reg;
		logic in_buf;
	} pwr_t;

	// bit order: comm, open wire, oscillator, regulator, undervoltage, overvoltage
	typedef struct packed {
		logic comm;
		logic open_wire;
		logic osc;
		logic regulator;
		logic under_v;
		logic over_v;
	} fault_t;

endpackage : pwr_mode_pkg

// ---- adc_far_model.sv ----
// Purpose: converter and host side model that answers each conversion start
// Assumes: start pulse is one cycle, sampled on the rising edge
// Notes:   data is only valid with the done pulse and toggles otherwise
`timescale 1ns/1ps
`include "pwr_mode_defs.svh"

module adc_far_model
(
	input  wire logic              core_clk_in,
	input  wire logic              start_in,
	input  wire logic [3:0]        chan_in,
	input  wire logic              slow_in,
	output logic                   done_out,
	output logic [`ADC_W-1:0]      data_out
);
	logic       pend_r;
	logic [3:0] chan_r;
	int         wait_cnt;

	initial
	begin
		done_out = 1'b0;
		data_out = 14'h1555;
		pend_r   = 1'b0;
	end

	// answer promptly or after a stall; data shows garbage outside the done cycle
	always @(posedge core_clk_in)
	begin
		done_out <= 1'b0;
		data_out <= ~data_out;
		if (start_in)
		begin
			pend_r   <= 1'b1;
			chan_r   <= chan_in;
			wait_cnt <= slow_in ? 7 : 0;
		end
		else if (pend_r)
		begin
			if (wait_cnt == 0)
			begin
				done_out <= 1'b1;
				data_out <= 14'h0200 + {6'h00, chan_r, 4'h0};
				pend_r   <= 1'b0;
			end
			else
				wait_cnt <= wait_cnt - 1;
		end
	end
endmodule : adc_far_model

// ---- tb_battery_power_ctrl.sv ----
// Purpose: self-checking bench for the power mode controller
// Assumes: 50 MHz clock, reset held 16 cycles, far side answered by adc_far_model
// Notes:   inputs change by non-blocking assignment on or 1 ns after the rising edge; slow by blocking assignment
`timescale 1ns/1ps
`include "pwr_mode_defs.svh"

module tb_battery_power_ctrl
	import pwr_mode_pkg::*;
;
	logic clk = 1'b0, rst_b = 1'b0, en = 1'b1, act = 1'b0, sup = 1'b1, slp = 1'b0;
	logic wdog = 1'b0, cmd_rx = 1'b0, op_req = 1'b0, done, tick = 1'b0, bal_tick = 1'b0;
	logic bal_go = 1'b0, reg_bad = 1'b0, osc_bad = 1'b0, cerr = 1'b0, slow = 1'b0;
	op_t                  op_sel = OP_SCAN_VOLT;
	bal_mode_t            bal_mode = BAL_OFF;
	logic [3:0]           op_chan = 4'h0, rd_addr = 4'h0, chan, chain_pos = 4'h3;
	logic                 busy, reply_err, unsol, chain_err;
	logic [`ADC_W-1:0]    data, rd_data;
	logic [11:0]          bal_mask = 12'h0a5, bal;
	mode_t                mode;
	pwr_t                 pwr;
	fault_t               fault;
	logic                 start, ow_src, cmd_pend, nvm_load;
	int                   error_cnt = 0, compares = 0, cyc = 0;

	always #10 clk = ~clk;

	battery_power_ctrl battery_power_ctrl_i (.core_clk_in(clk), .rst_b_in(rst_b),
		.en_pin_in(en), .comm_act_in(act), .supply_ok_in(sup), .sleep_cmd_in(slp),
		.wdog_to_in(wdog), .cmd_rx_in(cmd_rx), .op_req_in(op_req), .op_sel_in(op_sel),
		.op_chan_in(op_chan), .adc_done_in(done), .adc_data_in(data), .scan_tick_in(tick),
		.bal_tick_in(bal_tick), .bal_mode_in(bal_mode), .bal_mask_in(bal_mask),
		.bal_time_in(8'h10), .bal_go_in(bal_go), .ov_lim_in(14'h3fff), .uv_lim_in(14'h0000),
		.reg_bad_in(reg_bad), .osc_bad_in(osc_bad), .comm_err_in(cerr),
		.chain_pos_in(chain_pos), .rd_addr_in(rd_addr), .mode_out(mode), .pwr_out(pwr),
		.adc_start_out(start), .adc_chan_out(chan), .ow_src_out(ow_src), .busy_out(busy),
		.rd_data_out(rd_data), .fault_out(fault), .bal_out(bal), .cmd_pend_out(cmd_pend),
		.comm_reply_err_out(reply_err), .unsol_msg_out(unsol), .nvm_load_out(nvm_load),
		.chain_err_out(chain_err));

	adc_far_model adc_far_model_i (.core_clk_in(clk), .start_in(start), .chan_in(chan),
		.slow_in(slow), .done_out(done), .data_out(data));

	task give_verdict;
	begin
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask : give_verdict

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
	begin
		compares++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	end
	endtask : chk

	task tick_n(input int n);
	begin
		repeat (n) @(posedge clk);
		#1;
	end
	endtask : tick_n

	// bounded wait for a state; a miss is a mismatch
	task wait_mode(input mode_t m, input int lim);
		int i;
	begin
		for (i = 0; i < lim && mode !== m; i++)
			tick_n(1);
		chk(mode, m, "state not reached");
	end
	endtask : wait_mode

	// run one operation and follow each conversion the sequencer launches
	task run_op(input op_t op, input logic [3:0] first, input logic [3:0] last);
		int i, k;
	begin
		@(posedge clk);
		op_sel <= op;
		op_chan <= first;
		op_req <= 1'b1;
		@(posedge clk);
		op_req <= 1'b0;
		#1;
		chk(mode, ST_ACT, "not active");
		chk(busy, 1'b1, "sequencer idle");
		if (op == OP_OPEN_WIRE) chk(ow_src, 1'b1, "wire source off");
		for (i = first; i <= last; i++)
		begin
			for (k = 0; k < 12 && start !== 1'b1; k++)
				tick_n(1);
			chk(chan, i[3:0], "channel order");
			tick_n(1);
		end
		wait_mode(ST_STBY, 20);
	end
	endtask : run_op

	task read_res(input logic [3:0] idx, input logic [3:0] ch);
	begin
		@(posedge clk);
		rd_addr <= idx;
		tick_n(2);
		chk(rd_data, 14'h0200 + {6'h00, ch, 4'h0}, "stored result");
	end
	endtask : read_res

	task t_powerup;
	begin
		chk(mode, ST_SHUT, "reset state");
		chk(pwr, 9'b000000111, "reset power");
		@(posedge clk);
		rst_b <= 1'b1;
		wait_mode(ST_PWRUP, 5);
		chk(nvm_load, 1'b1, "first load");
		tick_n(40);
		chk(mode, ST_PWRUP, "settle too short");
		wait_mode(ST_STBY, 15);
		chk(pwr, 9'h1ff, "standby power");
	end
	endtask : t_powerup

	task t_ops;
		int i;
	begin
		run_op(OP_SCAN_VOLT, 4'h0, 4'hb);
		for (i = 0; i < 12; i++)
			read_res(i[3:0], i[3:0]);
		slow = 1'b1;
		run_op(OP_SCAN_ALL, 4'h0, 4'hf);
		read_res(4'hf, 4'hf);
		run_op(OP_DIRECT, 4'h5, 4'h5);
		slow = 1'b0;
		run_op(OP_OPEN_WIRE, 4'h0, 4'hb);
		chk(fault.open_wire, 1'b0, "wire fault");
	end
	endtask : t_ops

	task t_sleep;
	begin
		bal_mode <= BAL_MANUAL;
		tick_n(3);
		chk(bal, 12'h0a5, "manual balance");
		slp <= 1'b1;
		@(posedge clk);
		slp <= 1'b0;
		wait_mode(ST_SLEEP, 3);
		chk({pwr.bias, pwr.main_osc, pwr.analog}, 3'b000, "sleep off");
		chk({pwr.comm_in, pwr.lp_osc, pwr.regs}, 3'b111, "sleep on");
		tick_n(2);
		chk(bal, 12'h000, "balance in sleep");
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		wait_mode(ST_SLEEP_SCAN, 3);
		wait_mode(ST_SLEEP, 200);
		act <= 1'b1;
		wait_mode(ST_STBY, 6);
		chk(cmd_pend, 1'b1, "command pending");
		cmd_rx <= 1'b1;
		@(posedge clk);
		cmd_rx <= 1'b0;
		act <= 1'b0;
		tick_n(2);
		chk(cmd_pend, 1'b0, "pending cleared");
		bal_mode <= BAL_OFF;
		wdog <= 1'b1;
		@(posedge clk);
		wdog <= 1'b0;
		wait_mode(ST_SLEEP, 3);
		act <= 1'b1;
		wait_mode(ST_STBY, 6);
		act <= 1'b0;
		cmd_rx <= 1'b1;
		@(posedge clk);
		cmd_rx <= 1'b0;
	end
	endtask : t_sleep

	task t_fault;
		int k;
	begin
		reg_bad <= 1'b1;
		tick_n(2);
		chk(fault.regulator, 1'b0, "flag unfiltered");
		for (k = 0; k < 8 && fault.regulator !== 1'b1; k++)
			tick_n(1);
		chk(fault.regulator, 1'b1, "flag missing");
		reg_bad <= 1'b0;
		tick_n(4);
		chk(fault.regulator, 1'b0, "flag stuck");
	end
	endtask : t_fault

	// link fault: unsolicited pulse as the flag rises, error reply to the next command
	task t_link;
	begin
		cerr <= 1'b1;
		tick_n(4);
		chk(unsol, 1'b1, "no unsolicited message");
		chk(fault.comm, 1'b1, "link flag missing");
		cmd_rx <= 1'b1;
		@(posedge clk);
		cmd_rx <= 1'b0;
		#1;
		chk(reply_err, 1'b1, "no error reply");
		cerr <= 1'b0;
		tick_n(2);
		chk(reply_err, 1'b0, "error reply stuck");
		chk(chain_err, 1'b0, "legal position flagged");
		chain_pos <= 4'h0;
		tick_n(2);
		chk(chain_err, 1'b1, "position zero accepted");
		chain_pos <= 4'hf;
		tick_n(2);
		chk(chain_err, 1'b1, "position fifteen accepted");
		chain_pos <= 4'he;
		tick_n(2);
		chk(chain_err, 1'b0, "position fourteen refused");
	end
	endtask : t_link

	task t_shutdown;
	begin
		en <= 1'b0;
		wait_mode(ST_SHUT, 5);
		chk(pwr, 9'b000000111, "shutdown power");
		en <= 1'b1;
		wait_mode(ST_PWRUP, 5);
		chk(nvm_load, 1'b0, "reload on exit");
		wait_mode(ST_STBY, 60);
		read_res(4'h3, 4'h3);
	end
	endtask : t_shutdown

	// cut a hang short
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			give_verdict();
		end
	end

	initial
	begin
		tick_n(16);
		t_powerup();
		t_ops();
		t_sleep();
		t_fault();
		t_link();
		t_shutdown();
		give_verdict();
	end
endmodule : tb_battery_power_ctrl
